/* File: hw/ptt_pkg.sv */
// package of the period timer: register indices and byte addresses, field layout, reset values, counts
// assumes a 32-bit axi4-lite register bus and one 250 MHz system clock
package ptt_pkg;

  // printed offsets are not word aligned, so each is an index and the byte address is four times it
  localparam logic [15:0] PTT_IDX_CTRL = 16'hc000;
  localparam logic [15:0] PTT_IDX_START = 16'hc002;
  localparam logic [15:0] PTT_IDX_END = 16'hc004;
  localparam logic [15:0] PTT_IDX_CURR = 16'hc006;
  localparam logic [15:0] PTT_IDX_IRQ_STAT = 16'hc008;
  localparam logic [15:0] PTT_IDX_IRQ_MASK = 16'hc00a;

  localparam logic [31:0] PTT_ADDR_CTRL = {14'h0000, PTT_IDX_CTRL, 2'h0};
  localparam logic [31:0] PTT_ADDR_START = {14'h0000, PTT_IDX_START, 2'h0};
  localparam logic [31:0] PTT_ADDR_END = {14'h0000, PTT_IDX_END, 2'h0};
  localparam logic [31:0] PTT_ADDR_CURR = {14'h0000, PTT_IDX_CURR, 2'h0};
  localparam logic [31:0] PTT_ADDR_IRQ_STAT = {14'h0000, PTT_IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] PTT_ADDR_IRQ_MASK = {14'h0000, PTT_IDX_IRQ_MASK, 2'h0};

  // control register field positions
  localparam int PTT_BIT_RUN = 0;
  localparam int PTT_BIT_DIR = 1;
  localparam int PTT_BIT_RELOAD = 2;
  localparam int PTT_BIT_CONT = 3;
  localparam int PTT_BIT_TRIG_EN = 4;
  localparam int PTT_BIT_CLK_MODE = 5;
  localparam int PTT_POS_PRESCALE = 6;
  localparam int PTT_CTRL_USED = 10;

  // interrupt status bit positions
  localparam int PTT_IRQ_PERIOD_END = 0;
  localparam int PTT_IRQ_START_LOAD = 1;
  localparam int PTT_IRQ_W = 2;

  localparam logic [15:0] PTT_RST_REG = 16'h0000;
  localparam logic [PTT_IRQ_W-1:0] PTT_RST_IRQ = 2'h0;

  // prescaler: field n divides by 2**(n+2), n+2 up to 17 bits
  localparam int PTT_PRE_W = 17;
  localparam logic [4:0] PTT_PRE_BASE_SHIFT = 5'h02;
  // trigger pulse length in internal clock cycles
  localparam logic [1:0] PTT_TRIG_CYCLES = 2'h2;

  localparam logic [1:0] PTT_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTT_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] prescale_select;
    logic clock_mode_sel;
    logic trigger_out_enable;
    logic continue_mode;
    logic reload_enable;
    logic count_direction;
    logic run_enable;
  } ptt_ctrl_s;

endpackage

/* File: hw/ptt_timer.sv */
// period timer with trigger output: 16-bit up/down counter between start and end values,
// exponential prescaler, two-cycle converter trigger pulse, sticky interrupt status with mask.
// assumes an axi4-lite master on the same clock that keeps the bus rules and one access of each kind at a time.
// assumes software changes only run enable while the timer runs, and keeps clock mode at 0.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module ptt_timer (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_converter_inject_trigger,
  output logic o_irq
);

  // register state
  ptt_pkg::ptt_ctrl_s ctrl_r;
  logic [15:0] start_value_r;
  logic [15:0] end_value_r;
  logic [15:0] current_count_r;
  logic [ptt_pkg::PTT_IRQ_W-1:0] irq_stat_r;
  logic [ptt_pkg::PTT_IRQ_W-1:0] irq_mask_r;

  // axi write channel
  logic aw_full_r;
  logic w_full_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire do_write = aw_full_r & w_full_r & ~bvalid_r;

  assign o_awready = ~aw_full_r & ~bvalid_r;
  assign o_wready = ~w_full_r & ~bvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  wire wr_ctrl = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_CTRL);
  wire wr_start = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_START);
  wire wr_end = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_END);
  wire wr_curr = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_CURR);
  wire wr_stat = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_IRQ_STAT);
  wire wr_mask = do_write & (aw_addr_r == ptt_pkg::PTT_ADDR_IRQ_MASK);
  wire wr_hit = wr_ctrl | wr_start | wr_end | wr_curr | wr_stat | wr_mask;

  // byte-lane merge of a 16-bit register with the captured write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
    lane_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  wire [15:0] ctrl_q = {6'h00, ctrl_r};
  wire [15:0] ctrl_wval = lane_merge(ctrl_q, w_data_r, w_strb_r);
  wire [15:0] start_wval = lane_merge(start_value_r, w_data_r, w_strb_r);
  wire [15:0] end_wval = lane_merge(end_value_r, w_data_r, w_strb_r);
  wire [ptt_pkg::PTT_IRQ_W-1:0] stat_clr = w_strb_r[0] ? w_data_r[ptt_pkg::PTT_IRQ_W-1:0] : '0;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= i_awaddr;
    end else if (do_write) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= i_wdata;
      w_strb_r <= i_wstrb;
    end else if (do_write) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= ptt_pkg::PTT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? ptt_pkg::PTT_RESP_OKAY : ptt_pkg::PTT_RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // configuration registers
  // bits 15:10 of control are not implemented and read as zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= ptt_pkg::ptt_ctrl_s'(ptt_pkg::PTT_RST_REG[ptt_pkg::PTT_CTRL_USED-1:0]);
    end else if (wr_ctrl) begin
      ctrl_r <= ptt_pkg::ptt_ctrl_s'(ctrl_wval[ptt_pkg::PTT_CTRL_USED-1:0]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_value_r <= ptt_pkg::PTT_RST_REG;
    end else if (wr_start) begin
      start_value_r <= start_wval;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      end_value_r <= ptt_pkg::PTT_RST_REG;
    end else if (wr_end) begin
      end_value_r <= end_wval;
    end
  end

  // the interrupt output uses the next mask, so a mask write acts at the same edge as the mask
  wire [ptt_pkg::PTT_IRQ_W-1:0] irq_mask_nxt = (wr_mask && w_strb_r[0]) ? w_data_r[ptt_pkg::PTT_IRQ_W-1:0] : irq_mask_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_r <= ptt_pkg::PTT_RST_IRQ;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // prescaler
  logic [ptt_pkg::PTT_PRE_W-1:0] pre_cnt_r;
  wire [4:0] pre_shift = ptt_pkg::PTT_PRE_BASE_SHIFT + {1'b0, ctrl_r.prescale_select};
  wire [ptt_pkg::PTT_PRE_W:0] pre_one_hot = {{ptt_pkg::PTT_PRE_W{1'b0}}, 1'b1} << pre_shift;
  wire [ptt_pkg::PTT_PRE_W-1:0] pre_mask = pre_one_hot[ptt_pkg::PTT_PRE_W-1:0] - 1'b1;
  // the divider restarts with the timer so the first counting edge lands a full period after start
  // clock mode 1 has no second clock source here, so the count simply freezes
  wire count_clk_on = ctrl_r.run_enable & ~ctrl_r.clock_mode_sel;
  wire count_tick = count_clk_on & ((pre_cnt_r & pre_mask) == pre_mask);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_cnt_r <= '0;
    end else if (!count_clk_on) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  // counter core
  logic run_prev_r;
  logic load_pending_r;
  logic [15:0] current_count_nxt;
  wire run_rise = ctrl_r.run_enable & ~run_prev_r;
  wire at_end = (current_count_r == end_value_r);
  wire [15:0] count_inc = current_count_r + 16'h0001;
  wire [15:0] count_dec = current_count_r - 16'h0001;
  wire [15:0] count_step = ctrl_r.count_direction ? count_inc : count_dec;
  wire first_load = count_tick & load_pending_r;

  always_comb begin
    current_count_nxt = current_count_r;
    if (!ctrl_r.run_enable) begin
      current_count_nxt = current_count_r;
    end else if (first_load) begin
      current_count_nxt = start_value_r;
    end else if (count_tick) begin
      if (!at_end) begin
        current_count_nxt = count_step;
      end else if (!ctrl_r.continue_mode) begin
        current_count_nxt = current_count_r;
      end else if (ctrl_r.reload_enable) begin
        current_count_nxt = start_value_r;
      end else begin
        current_count_nxt = count_step;
      end
    end
  end

  // the current count has no write path: software writes to it are accepted and dropped
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      current_count_r <= ptt_pkg::PTT_RST_REG;
    end else begin
      current_count_r <= current_count_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_prev_r <= 1'b0;
      load_pending_r <= 1'b0;
    end else begin
      run_prev_r <= ctrl_r.run_enable;
      if (run_rise) begin
        load_pending_r <= 1'b1;
      end else if (first_load || !ctrl_r.run_enable) begin
        load_pending_r <= 1'b0;
      end
    end
  end

  // trigger output
  // equality only counts while the timer runs and after the start load, so a stopped
  // timer resting at its end value does not fire; the start edge itself is masked as well,
  // because the count there still holds what the previous run left behind
  logic eq_prev_r;
  logic [1:0] trig_cnt_r;
  logic trig_r;
  wire eq_flag = at_end & ctrl_r.run_enable & ~load_pending_r & ~run_rise;
  wire eq_rise = eq_flag & ~eq_prev_r;
  wire trig_fire = eq_rise & ctrl_r.trigger_out_enable;
  logic [1:0] trig_cnt_nxt;

  always_comb begin
    trig_cnt_nxt = 2'h0;
    if (!ctrl_r.trigger_out_enable) begin
      trig_cnt_nxt = 2'h0;
    end else if (trig_fire) begin
      trig_cnt_nxt = ptt_pkg::PTT_TRIG_CYCLES;
    end else if (trig_cnt_r != 2'h0) begin
      trig_cnt_nxt = trig_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eq_prev_r <= 1'b0;
      trig_cnt_r <= 2'h0;
      trig_r <= 1'b0;
    end else begin
      eq_prev_r <= eq_flag;
      trig_cnt_r <= trig_cnt_nxt;
      trig_r <= (trig_cnt_nxt != 2'h0);
    end
  end

  assign o_converter_inject_trigger = trig_r;

  // interrupts
  // a new event beats a clearing write in the same cycle
  wire [ptt_pkg::PTT_IRQ_W-1:0] irq_set = {first_load, eq_rise};
  wire [ptt_pkg::PTT_IRQ_W-1:0] irq_clr = wr_stat ? stat_clr : '0;
  wire [ptt_pkg::PTT_IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  logic irq_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= ptt_pkg::PTT_RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  assign o_irq = irq_r;

  // axi read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = i_arvalid & o_arready;

  // decoded from the live address, which the master holds until arready takes it
  wire rd_ctrl = (i_araddr == ptt_pkg::PTT_ADDR_CTRL);
  wire rd_start = (i_araddr == ptt_pkg::PTT_ADDR_START);
  wire rd_end = (i_araddr == ptt_pkg::PTT_ADDR_END);
  wire rd_curr = (i_araddr == ptt_pkg::PTT_ADDR_CURR);
  wire rd_stat = (i_araddr == ptt_pkg::PTT_ADDR_IRQ_STAT);
  wire rd_mask = (i_araddr == ptt_pkg::PTT_ADDR_IRQ_MASK);
  wire rd_hit = rd_ctrl | rd_start | rd_end | rd_curr | rd_stat | rd_mask;
  wire [15:0] rd_val = ({16{rd_ctrl}} & ctrl_q)
                     | ({16{rd_start}} & start_value_r)
                     | ({16{rd_end}} & end_value_r)
                     | ({16{rd_curr}} & current_count_r)
                     | ({16{rd_stat}} & {14'h0000, irq_stat_r})
                     | ({16{rd_mask}} & {14'h0000, irq_mask_r});

  assign o_arready = ~rvalid_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ptt_pkg::PTT_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_val};
      rresp_r <= rd_hit ? ptt_pkg::PTT_RESP_OKAY : ptt_pkg::PTT_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: tb/ptt_timer_sva.sv */
// checker of the period timer ports: bus handshakes, read data shape, trigger pulse
// assumes it is bound to ptt_timer and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module ptt_timer_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic i_rready,
  input wire logic o_converter_inject_trigger
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic mapped = (i_araddr[31:6] == ptt_pkg::PTT_ADDR_CTRL[31:6]) && (i_araddr[2:0] == 3'h0)
    && (i_araddr[5:3] < 3'h6);

  a_trig_two_cycles: assert property ($rose(o_converter_inject_trigger) |=> o_converter_inject_trigger ##1
    !o_converter_inject_trigger) else $error("trigger pulse not two cycles long");
  a_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before ready");
  a_b_once: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("write response repeated");
  a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken during response");
  a_ar_answer: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
  a_ar_blocked: assert property (o_arready != o_rvalid) else $error("read ready not inverse of rvalid");
  a_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data changed before ready");
  a_rd_upper_zero: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_rd_unmapped: assert property (i_arvalid && o_arready && !mapped |=> o_rresp == ptt_pkg::PTT_RESP_SLVERR
    && o_rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind ptt_timer ptt_timer_sva sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_awready(o_awready),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(i_bready), .i_araddr(i_araddr),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .i_rready(i_rready), .o_converter_inject_trigger(o_converter_inject_trigger));
`default_nettype wire

/* File: tb/test_period_timer_with_trigger.sv */
// self-checking bench of the period timer: registers, counting, trigger and interrupt
// assumes ptt_pkg and ptt_timer are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_period_timer_with_trigger;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd, rd2, rdata, lfsr = 32'h4fdba0bb;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trig, irq, tprev = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] c;
  logic [31:0] regs [6] = '{ptt_pkg::PTT_ADDR_CTRL, ptt_pkg::PTT_ADDR_START, ptt_pkg::PTT_ADDR_END,
    ptt_pkg::PTT_ADDR_CURR, ptt_pkg::PTT_ADDR_IRQ_STAT, ptt_pkg::PTT_ADDR_IRQ_MASK};
  int mismatches = 0, n_tests = 0, cyc = 0, rises = 0, last_rise = 0, last_gap = 0, t0, r0;

  ptt_timer uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_converter_inject_trigger(trig), .o_irq(irq));

  always #2 clk = ~clk;

  task automatic finish_test();
    $display("counts: %0d mismatches in %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // trigger rises are counted at the falling edge, where the output has settled
  always @(negedge clk) begin
    if (trig === 1'b1 && tprev === 1'b0) begin
      rises++;
      last_gap = cyc - last_rise;
      last_rise = cyc;
    end
    tprev = trig;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // ten counting edges of 2**(n+2) cycles after the run edge, plus one edge for the registered trigger
  function automatic int exp_rise_delay(input int n);
    return 10 * (4 << n) + 1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready is looked at on the falling edge, so the value seen is the one the next rising edge samples
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ap, wp, ar, wt;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    {ap, wp} = 2'h3;
    while (ap || wp) begin
      @(negedge clk);
      {ar, wt} = {awready === 1'b1, wready === 1'b1};
      @(posedge clk);
      if (ap && ar) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wt) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rdt(input logic [31:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    {rd, rs} = {rdata, rresp};
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wait_rise(input int n);
    r0 = rises;
    while (rises < r0 + n) @(negedge clk);
  endtask

  task automatic run_cfg(input logic [15:0] s, input logic [15:0] e, input logic [15:0] ctl);
    wr(ptt_pkg::PTT_ADDR_START, {16'h0, s});
    wr(ptt_pkg::PTT_ADDR_END, {16'h0, e});
    wr(ptt_pkg::PTT_ADDR_CTRL, {16'h0, ctl});
    wr(ptt_pkg::PTT_ADDR_CTRL, {16'h0, ctl | 16'h0001});
    t0 = cyc;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdt(regs[i]);
      chk(rd, 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(next_rand(lfsr));
      c = lfsr[15:0] ^ lfsr[31:16];
      run_cfg(lfsr[15:0], lfsr[31:16], 16'h0000);
      wr(ptt_pkg::PTT_ADDR_CTRL, 32'h0);
      wr(ptt_pkg::PTT_ADDR_CTRL, {16'h0, c & 16'hfffe});
      for (int j = 0; j < 3; j++) begin
        rdt(regs[j]);
        chk(rd, j == 0 ? {16'h0, c & 16'h03fe} : j == 1 ? {16'h0, lfsr[15:0]} : {16'h0, lfsr[31:16]});
      end
    end
    wr(ptt_pkg::PTT_ADDR_CTRL, 32'h0);
    wr(ptt_pkg::PTT_ADDR_CURR, 32'h1234);
    chk(rs, ptt_pkg::PTT_RESP_OKAY);
    rdt(ptt_pkg::PTT_ADDR_CURR);
    // each random run was stopped on the edge of its first load, leaving the last start value
    chk(rd, {16'h0, lfsr[15:0]});
    wr(32'h00040000, 32'h1);
    chk(rs, ptt_pkg::PTT_RESP_SLVERR);
    rdt(32'h00040000);
    chk(rs, ptt_pkg::PTT_RESP_SLVERR);
    $display("test register access done");
    // up count 0 to 9 in stop mode: ten ticks of 2**(n+2) cycles before the trigger
    for (int n = 0; n < 2; n++) begin
      c = 16'h0012 | (16'(n) << ptt_pkg::PTT_POS_PRESCALE);
      run_cfg(16'h0000, 16'h0009, c);
      wait_rise(1);
      chk(32'(last_rise - t0), 32'(exp_rise_delay(n)));
      repeat (40) @(negedge clk);
      rdt(ptt_pkg::PTT_ADDR_CURR);
      chk(rd, 32'h9);
      chk(32'(rises), 32'(r0 + 1));
      wr(ptt_pkg::PTT_ADDR_CTRL, {16'h0, c});
    end
    chk({31'h0, irq}, 32'h0);
    wr(ptt_pkg::PTT_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ptt_pkg::PTT_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rdt(ptt_pkg::PTT_ADDR_IRQ_STAT);
    chk(rd, 32'h2);
    wr(ptt_pkg::PTT_ADDR_IRQ_STAT, 32'h2);
    wr(ptt_pkg::PTT_ADDR_IRQ_MASK, 32'h0);
    $display("test count and interrupt done");
    // down count 5..2 with reload: one trigger every four ticks of four cycles
    run_cfg(16'h0005, 16'h0002, 16'h001c);
    wait_rise(2);
    chk(32'(last_gap), 32'd16);
    wr(ptt_pkg::PTT_ADDR_CTRL, 32'h001c);
    run_cfg(16'h0005, 16'h0002, 16'h000c);
    r0 = rises;
    repeat (60) @(negedge clk);
    chk(32'(rises), 32'(r0));
    wr(ptt_pkg::PTT_ADDR_CTRL, 32'h000c);
    $display("test reload and trigger enable done");
    run_cfg(16'h0003, 16'h0001, 16'h0018);
    wait_rise(1);
    repeat (12) @(negedge clk);
    rdt(ptt_pkg::PTT_ADDR_CURR);
    chk(32'(rd == 32'h0 || rd[15:4] == 12'hfff), 32'h1);
    wr(ptt_pkg::PTT_ADDR_CTRL, 32'h0018);
    rdt(ptt_pkg::PTT_ADDR_CURR);
    rd2 = rd;
    repeat (20) @(negedge clk);
    rdt(ptt_pkg::PTT_ADDR_CURR);
    chk(rd, rd2);
    $display("test continue and hold done");
    finish_test();
  end
endmodule
`default_nettype wire
